// ### rtl/lfpc_pin_control.sv
// pin-level control of the low-pin-count flash: mode, resets, strap select, inputs, write protect
`timescale 1ns/1ps
module lfpc_pin_control
  import lfpc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic reset_pin_n,
  input wire logic init_pin_n,
  input wire logic parallel_program_mode,
  input wire logic lframe_n,
  input wire logic [3:0] lad_in,
  output logic [3:0] lad_out,
  output logic lad_oe,
  input wire logic [3:0] chip_select_strap,
  input wire logic [GPI_W-1:0] general_input_pins,
  input wire logic top_boot_lock_n,
  input wire logic write_protect_n,
  output lfpc_mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  output logic prog_refused,
  output logic lpc_mode_active,
  output logic dev_in_reset
);
  // programming permission: top block under the lock pin, the rest under write protect
  function automatic logic prog_allowed(input logic [ARRAY_AW-1:0] a, input logic tbl_n, input logic wp_n);
    if (a[ARRAY_AW-1:BLOCK_SEL_LSB] == TOP_BLOCK) begin
      prog_allowed = tbl_n;
    end else begin
      prog_allowed = wp_n;
    end
  endfunction

  // two-stage synchronisers for every pin; first stage read only by the second
  logic [1:0] rstp_sync_reg; // primary reset pin
  logic [1:0] init_sync_reg; // second reset pin
  logic [1:0] mode_sync_reg; // interface select
  logic [1:0] frame_sync_reg; // frame strobe
  logic [3:0] lad_s1_reg, lad_s2_reg; // address/data lines
  logic [3:0] strap_s1_reg, strap_s2_reg; // select strap
  logic [GPI_W-1:0] gpi_s1_reg, gpi_s2_reg; // general inputs
  logic [1:0] tbl_sync_reg; // top block lock
  logic [1:0] wp_sync_reg; // write protect

  // synchronisers only clear on the system reset so the pin resets still propagate
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rstp_sync_reg <= 2'h0;
      init_sync_reg <= 2'h0;
      mode_sync_reg <= 2'h0;
      frame_sync_reg <= 2'h3;
      lad_s1_reg <= 4'hF;
      lad_s2_reg <= 4'hF;
      strap_s1_reg <= 4'h0;
      strap_s2_reg <= 4'h0;
      gpi_s1_reg <= '0;
      gpi_s2_reg <= '0;
      tbl_sync_reg <= 2'h0;
      wp_sync_reg <= 2'h0;
    end else if (clk_en) begin
      rstp_sync_reg <= {rstp_sync_reg[0], reset_pin_n};
      init_sync_reg <= {init_sync_reg[0], init_pin_n};
      mode_sync_reg <= {mode_sync_reg[0], parallel_program_mode};
      frame_sync_reg <= {frame_sync_reg[0], lframe_n};
      lad_s1_reg <= lad_in;
      lad_s2_reg <= lad_s1_reg;
      strap_s1_reg <= chip_select_strap;
      strap_s2_reg <= strap_s1_reg;
      gpi_s1_reg <= general_input_pins;
      gpi_s2_reg <= gpi_s1_reg;
      tbl_sync_reg <= {tbl_sync_reg[0], top_boot_lock_n};
      wp_sync_reg <= {wp_sync_reg[0], write_protect_n};
    end
  end

  // either reset pin has the same effect; the mode pin is trusted to be static
  logic dev_rst; // combined device reset
  logic lpc_en; // LPC interface selected
  assign dev_rst = sys_rst | ~rstp_sync_reg[1] | ~init_sync_reg[1];
  assign lpc_en = ~mode_sync_reg[1];

  // cycle tracking state
  lfpc_state_t state_reg, state_next; // decode state
  logic [2:0] cnt_reg, cnt_next; // nibble counter within a field
  logic is_write_reg, is_write_next; // current cycle direction
  logic [27:0] addr_reg, addr_next; // assembled cycle address
  logic [7:0] wdata_reg, wdata_next; // byte to program
  logic [7:0] rdata_reg; // byte to return
  logic frame_act; // frame asserted this cycle
  logic reg_hit; // address selects the general input status
  assign frame_act = ~frame_sync_reg[1];
  assign reg_hit = ~addr_reg[REG_SPACE_BIT] && (addr_reg[15:0] == GPI_STATUS_OFS);

  // next-state decode; in LPC mode frame low always restarts, which aborts anything in flight
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    is_write_next = is_write_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    if (!lpc_en) begin
      state_next = ST_IDLE; // parallel mode: LPC decoder parked
    end else if (frame_act) begin
      state_next = ST_START;
      is_write_next = (lad_s2_reg == START_WRITE);
      // a count of one marks an unknown start code, so the select step turns the cycle away
      cnt_next = (lad_s2_reg == START_READ || lad_s2_reg == START_WRITE) ? 3'h0 : 3'h1;
    end else begin
      case (state_reg)
        ST_START: begin
          // first nibble after frame is the device select field
          cnt_next = 3'h0;
          if (cnt_reg == 3'h0 && lad_s2_reg == strap_s2_reg) begin
            state_next = ST_ADDR;
          end else begin
            state_next = ST_IDLE; // other device selected
          end
        end
        ST_ADDR: begin
          addr_next = {addr_reg[23:0], lad_s2_reg};
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == ADDR_LAST) begin
            state_next = ST_MSIZE;
            cnt_next = 3'h0;
          end
        end
        ST_MSIZE: begin
          // only single-byte size is supported; the field is accepted as is
          state_next = is_write_reg ? ST_WDATA : ST_TAR_IN;
        end
        ST_WDATA: begin
          // data arrives low nibble first
          wdata_next = {lad_s2_reg, wdata_reg[7:4]};
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == 3'h1) begin
            state_next = ST_TAR_IN;
            cnt_next = 3'h0;
          end
        end
        ST_TAR_IN: begin
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == 3'h1) begin
            state_next = ST_SYNC;
            cnt_next = 3'h0;
          end
        end
        ST_SYNC: begin
          state_next = is_write_reg ? ST_TAR_OUT : ST_RDATA;
        end
        ST_RDATA: begin
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == 3'h1) begin
            state_next = ST_TAR_OUT;
            cnt_next = 3'h0;
          end
        end
        ST_TAR_OUT: begin
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == 3'h1) begin
            state_next = ST_IDLE;
            cnt_next = 3'h0;
          end
        end
        default: begin
          state_next = ST_IDLE; // idle and unknown codes wait for a frame
        end
      endcase
    end
  end

  // decode state registers
  always_ff @(posedge mclk) begin
    if (dev_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 3'h0;
      is_write_reg <= 1'b0;
      addr_reg <= 28'h0000000;
      wdata_reg <= 8'h00;
    end else if (clk_en) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      is_write_reg <= is_write_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
    end
  end

  // array request, decided in the last host turnaround nibble and seen in the sync cycle; writes checked against the pins
  logic req_now; // request point of the cycle
  logic allow; // programming permitted at this address
  assign req_now = lpc_en && !frame_act && state_reg == ST_TAR_IN && cnt_reg == 3'h1;
  assign allow = prog_allowed(addr_reg[ARRAY_AW-1:0], tbl_sync_reg[1], wp_sync_reg[1]);
  always_ff @(posedge mclk) begin
    if (dev_rst) begin
      mem_req <= '0;
      prog_refused <= 1'b0;
    end else if (clk_en) begin
      mem_req.valid <= req_now && addr_reg[REG_SPACE_BIT] && (!is_write_reg || allow);
      mem_req.write <= is_write_reg;
      mem_req.addr <= addr_reg[ARRAY_AW-1:0];
      mem_req.data <= wdata_reg;
      prog_refused <= req_now && is_write_reg && addr_reg[REG_SPACE_BIT] && !allow;
    end
  end

  // read byte capture: status register or array answer in the sync cycle
  always_ff @(posedge mclk) begin
    if (dev_rst) begin
      rdata_reg <= 8'h00;
    end else if (clk_en && state_reg == ST_SYNC) begin
      if (!addr_reg[REG_SPACE_BIT]) begin
        // unmapped register offsets read as zero
        rdata_reg <= reg_hit ? {{(8-GPI_W){1'b0}}, gpi_s2_reg} : 8'h00;
      end else begin
        rdata_reg <= mem_rdata;
      end
    end
  end

  // low nibble of the byte being captured in the sync cycle
  logic [3:0] rdata_next_lo;
  assign rdata_next_lo = !addr_reg[REG_SPACE_BIT] ?
    (reg_hit ? gpi_s2_reg[3:0] : 4'h0) : mem_rdata[3:0];

  // line drive follows the next state so the byte appears as the state is entered
  logic [3:0] drv_val; // level to drive next
  logic drv_en; // drive next
  always_comb begin
    drv_val = TAR_DRIVE;
    drv_en = 1'b0;
    if (lpc_en && !frame_act) begin
      case (state_next)
        ST_SYNC: begin
          drv_val = SYNC_READY;
          drv_en = 1'b1;
        end
        ST_RDATA: begin
          // the captured byte is only ready after sync, so the low nibble comes from the live answer, the high one from the captured byte
          drv_val = (cnt_next == 3'h0) ? rdata_next_lo : rdata_reg[7:4];
          drv_en = 1'b1;
        end
        ST_TAR_OUT: begin
          drv_val = TAR_DRIVE;
          drv_en = (cnt_next == 3'h0); // drive high one nibble, then release
        end
        default: begin
          drv_val = TAR_DRIVE;
          drv_en = 1'b0;
        end
      endcase
    end
  end

  // registered line drivers; released on reset and on any abort
  always_ff @(posedge mclk) begin
    if (dev_rst) begin
      lad_out <= TAR_DRIVE;
      lad_oe <= 1'b0;
    end else if (clk_en) begin
      lad_out <= drv_val;
      lad_oe <= drv_en;
    end
  end

  // status levels for the surrounding logic
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lpc_mode_active <= 1'b0;
      dev_in_reset <= 1'b1;
    end else if (clk_en) begin
      lpc_mode_active <= lpc_en;
      dev_in_reset <= dev_rst;
    end
  end
endmodule

// ### rtl/lfpc_pkg.sv
// shared constants and types for the low-pin-count flash pin control block
package lfpc_pkg;
  // cycle field encodings seen on the address/data lines
  localparam logic [3:0] START_READ = 4'hD; // firmware memory read start code
  localparam logic [3:0] START_WRITE = 4'hE; // firmware memory write start code
  localparam logic [3:0] SYNC_READY = 4'h0; // sync code: ready, no wait
  localparam logic [3:0] TAR_DRIVE = 4'hF; // level driven during turnaround
  // field lengths in nibbles
  localparam logic [2:0] ADDR_LAST = 3'h6; // seven address nibbles, index 0..6
  // memory array geometry
  localparam int ARRAY_AW = 19; // byte address width of the array
  localparam int BLOCK_SEL_LSB = 16; // 64 kbyte block select starts here
  localparam logic [2:0] TOP_BLOCK = 3'h7; // highest block holds the boot code
  // register space decode
  localparam int REG_SPACE_BIT = 22; // low selects register space
  localparam logic [15:0] GPI_STATUS_OFS = 16'h0100; // general input status offset
  localparam int GPI_W = 5; // number of general-purpose inputs
  // request carried to the memory array
  typedef struct packed {
    logic valid; // one-cycle request strobe
    logic write; // high programs, low reads
    logic [ARRAY_AW-1:0] addr; // byte address in the array
    logic [7:0] data; // byte to program
  } lfpc_mem_req_t;
  // cycle decode states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_START = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_MSIZE = 4'b0011,
    ST_WDATA = 4'b0100,
    ST_TAR_IN = 4'b0101,
    ST_SYNC = 4'b0110,
    ST_RDATA = 4'b0111,
    ST_TAR_OUT = 4'b1000
  } lfpc_state_t;
endpackage

// ### tb/lfpc_host_model.sv
// chipset side model: frames cycles, shifts nibbles, collects the reply
`timescale 1ns/1ps
module lfpc_host_model
  import lfpc_pkg::*;
(
  input wire logic mclk,
  input wire logic [3:0] lad_out,
  input wire logic lad_oe,
  output logic lframe_n,
  output logic [3:0] lad_in
);
  logic host_oe = 1'b0; // host drives the lines
  logic [3:0] host_val = 4'hF; // nibble the host drives
  // released lines show the inverse, so a stale value never passes
  assign lad_in = lad_oe ? lad_out : (host_oe ? host_val : ~host_val);
  initial lframe_n = 1'b1;
  // one nibble per cycle, changed at the falling edge
  task automatic put(input logic [3:0] v);
    @(negedge mclk);
    host_val = v;
  endtask
  // one memory cycle; resp tells whether the device answered
  task automatic xfer(input logic wr, input logic [3:0] sel, input logic [27:0] adr, input logic [7:0] wd,
                      output logic resp, output logic [3:0] syn, output logic [7:0] rd);
    resp = 1'b0;
    syn = 4'hF;
    rd = 8'hFF;
    @(negedge mclk);
    lframe_n = 1'b0;
    host_oe = 1'b1;
    host_val = wr ? START_WRITE : START_READ;
    @(negedge mclk);
    lframe_n = 1'b1;
    host_val = sel;
    for (int i = 6; i >= 0; i--) put(adr[i*4 +: 4]);
    put(4'h0); // size: one byte
    if (wr) begin
      put(wd[3:0]);
      put(wd[7:4]);
    end
    put(TAR_DRIVE);
    @(negedge mclk);
    host_oe = 1'b0;
    // the reply comes late since every pin passes two flops
    for (int n = 0; n < 8 && !resp; n++) begin
      @(negedge mclk);
      resp = (lad_oe === 1'b1);
    end
    syn = lad_out;
    if (resp && !wr) begin
      put(4'h0);
      rd[3:0] = lad_out;
      put(4'h0);
      rd[7:4] = lad_out;
    end
    repeat (4) @(negedge mclk);
  endtask
  // cut cycle: start code st, select 3, n zero nibbles, then a frame with code F aborts it
  task automatic cut(input logic [3:0] st, input int n, output logic seen);
    seen = 1'b0;
    @(negedge mclk);
    lframe_n = 1'b0;
    host_oe = 1'b1;
    host_val = st;
    @(negedge mclk);
    lframe_n = 1'b1;
    host_val = 4'h3;
    repeat (n) put(4'h0);
    @(negedge mclk);
    lframe_n = 1'b0;
    host_val = TAR_DRIVE;
    @(negedge mclk);
    lframe_n = 1'b1;
    host_oe = 1'b0;
    // long enough to see a sync that a broken abort would still send
    repeat (12) begin
      @(negedge mclk);
      seen = seen | (lad_oe !== 1'b0);
    end
  endtask
endmodule

// ### tb/lfpc_pin_control_properties.sv
// concurrent checks on the flash pin control ports
`timescale 1ns/1ps
module lfpc_pin_control_properties
  import lfpc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic parallel_program_mode,
  input wire logic reset_pin_n,
  input wire logic init_pin_n,
  input wire logic top_boot_lock_n,
  input wire logic write_protect_n,
  input wire logic [3:0] lad_out,
  input wire logic lad_oe,
  input wire lfpc_mem_req_t mem_req,
  input wire logic prog_refused,
  input wire logic lpc_mode_active,
  input wire logic dev_in_reset
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  AST_PP_QUIET: assert property (parallel_program_mode [*8] |-> !lpc_mode_active && !lad_oe)
    else $error("bus active in parallel mode");
  AST_RST_PIN: assert property (!reset_pin_n [*5] |-> dev_in_reset && !lad_oe)
    else $error("reset pin ignored");
  AST_INIT_PIN: assert property (!init_pin_n [*5] |-> dev_in_reset && !lad_oe)
    else $error("second reset pin ignored");
  AST_RST_IDLE: assert property (dev_in_reset |-> !mem_req.valid && !prog_refused)
    else $error("array touched in reset");
  AST_SYNC_FIRST: assert property ($rose(lad_oe) |-> lad_out == SYNC_READY)
    else $error("drive not opened by sync");
  // read: sync, two data nibbles, closing nibble, then release
  AST_READ_DRIVE: assert property (mem_req.valid && !mem_req.write |->
    lad_oe ##1 lad_oe [*2] ##1 lad_oe && lad_out == TAR_DRIVE ##1 !lad_oe)
    else $error("read drive length wrong");
  AST_WRITE_DRIVE: assert property (mem_req.valid && mem_req.write |->
    lad_oe ##1 lad_oe && lad_out == TAR_DRIVE ##1 !lad_oe)
    else $error("write drive length wrong");
  AST_REFUSE_DRIVE: assert property (prog_refused |->
    lad_oe && !mem_req.valid ##1 lad_oe && !prog_refused ##1 !lad_oe)
    else $error("refused write ended badly");
  AST_TOP_LOCK: assert property (mem_req.valid && mem_req.write && mem_req.addr[18:16] == TOP_BLOCK |->
    $past(top_boot_lock_n, 3))
    else $error("locked top block programmed");
  AST_OTHER_WP: assert property (mem_req.valid && mem_req.write && mem_req.addr[18:16] != TOP_BLOCK |->
    $past(write_protect_n, 3))
    else $error("protected block programmed");
  COV_WRITE: cover property (mem_req.valid && mem_req.write);
  COV_REFUSE: cover property (prog_refused);
  COV_READ: cover property (mem_req.valid && !mem_req.write);
endmodule

// ### tb/lfpc_pin_control_tb.sv
// self-checking bench for the flash pin control block
`timescale 1ns/1ps
module lfpc_pin_control_tb
  import lfpc_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1; // gated once in the freeze scenario
  logic reset_pin_n = 1'b1;
  logic init_pin_n = 1'b1;
  logic parallel_program_mode = 1'b0;
  logic lframe_n;
  logic [3:0] lad_in;
  logic [3:0] lad_out;
  logic lad_oe;
  logic [3:0] chip_select_strap = 4'h3;
  logic [GPI_W-1:0] general_input_pins = 5'h00;
  logic top_boot_lock_n = 1'b1;
  logic write_protect_n = 1'b1;
  lfpc_mem_req_t mem_req;
  logic [7:0] mem_rdata;
  logic prog_refused;
  logic lpc_mode_active;
  logic dev_in_reset;
  logic [18:0] last_addr = 19'h00000; // last array address requested
  logic [7:0] last_wd = 8'h00; // last byte programmed
  logic resp;
  logic [3:0] syn;
  logic [7:0] rd;
  int error_cnt = 0;
  int checks_done = 0;
  int wr_cnt = 0;
  int ref_cnt = 0;
  int cyc = 0;
  initial begin
    forever #50 mclk = ~mclk;
  end
  lfpc_pin_control lfpc_pin_control_i (.mclk, .sys_rst, .clk_en, .reset_pin_n, .init_pin_n, .parallel_program_mode,
    .lframe_n, .lad_in, .lad_out, .lad_oe, .chip_select_strap, .general_input_pins, .top_boot_lock_n,
    .write_protect_n, .mem_req, .mem_rdata, .prog_refused, .lpc_mode_active, .dev_in_reset);
  lfpc_host_model lfpc_host_model_i (.mclk, .lad_out, .lad_oe, .lframe_n, .lad_in);
  // array stand-in answers in the request cycle and holds it after
  assign mem_rdata = 8'h5A ^ (mem_req.valid ? mem_req.addr[7:0] : last_addr[7:0]);
  // request monitor and run limit
  always @(posedge mclk) begin
    cyc++;
    if (mem_req.valid) last_addr <= mem_req.addr;
    if (mem_req.valid && mem_req.write) wr_cnt++;
    if (mem_req.valid && mem_req.write) last_wd <= mem_req.data;
    if (prog_refused) ref_cnt++;
    if (cyc == 4000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic xf(input logic wr, input logic [3:0] sel, input logic [27:0] adr);
    lfpc_host_model_i.xfer(wr, sel, adr, 8'hA5, resp, syn, rd);
  endtask
  // mode pin only changes while reset holds the device
  task automatic mode_set(input logic pp);
    reset_pin_n = 1'b0;
    parallel_program_mode = pp;
    repeat (6) @(negedge mclk);
    reset_pin_n = 1'b1;
    repeat (8) @(negedge mclk);
  endtask
  task automatic t_reset();
    repeat (6) @(negedge mclk);
    check({dev_in_reset, lad_oe, mem_req.valid}, 3'b100);
    sys_rst = 1'b0;
    repeat (8) @(negedge mclk);
    check({dev_in_reset, lpc_mode_active}, 2'b01);
  endtask
  task automatic t_read_strap();
    for (int s = 0; s < 16; s += 5) begin
      chip_select_strap = 4'(s);
      xf(1'b0, 4'(s), 28'hFFF0A5C);
      check({resp, syn, rd}, {1'b1, SYNC_READY, 8'h06});
      check(last_addr, 19'h70A5C);
      xf(1'b0, 4'(s + 1), 28'hFFF0A5C);
      check(resp, 1'b0);
    end
    chip_select_strap = 4'h3;
  endtask
  task automatic t_gpi();
    for (int v = 5'h15; v > 0; v -= 5'h0B) begin
      general_input_pins = 5'(v);
      xf(1'b0, 4'h3, 28'hFBF0100);
      check({resp, rd[4:0]}, {1'b1, 5'(v)});
    end
  endtask
  // every lock pin pairing against the top block and a low block
  task automatic t_protect();
    int base;
    logic ok;
    for (int k = 0; k < 8; k++) begin
      top_boot_lock_n = k[0];
      write_protect_n = k[1];
      ok = k[2] ? k[0] : k[1];
      base = wr_cnt + 2 * ref_cnt;
      xf(1'b1, 4'h3, k[2] ? 28'hFF70000 : 28'hFF10000);
      check({resp, syn}, {1'b1, SYNC_READY});
      check(wr_cnt + 2 * ref_cnt - base, ok ? 1 : 2);
    end
    check(last_wd, 8'hA5);
  endtask
  // bad start code, abort in the address field, then a frozen clock enable over a short reset pulse
  task automatic t_cut();
    logic seen;
    lfpc_host_model_i.cut(4'h0, 13, seen);
    check(seen, 1'b0);
    lfpc_host_model_i.cut(START_READ, 4, seen);
    check(seen, 1'b0);
    xf(1'b0, 4'h3, 28'hFFF0A5C);
    check({resp, rd}, {1'b1, 8'h06});
    clk_en = 1'b0;
    reset_pin_n = 1'b0;
    repeat (4) @(negedge mclk);
    reset_pin_n = 1'b1;
    repeat (2) @(negedge mclk);
    check(dev_in_reset, 1'b0);
    clk_en = 1'b1;
    repeat (6) @(negedge mclk);
    check(dev_in_reset, 1'b0);
  endtask
  task automatic t_pins();
    for (int p = 0; p < 2; p++) begin
      reset_pin_n = p[0];
      init_pin_n = !p[0];
      repeat (6) @(negedge mclk);
      check({dev_in_reset, lad_oe}, 2'b10);
      reset_pin_n = 1'b1;
      init_pin_n = 1'b1;
      repeat (6) @(negedge mclk);
      check(dev_in_reset, 1'b0);
    end
    mode_set(1'b1);
    xf(1'b0, 4'h3, 28'hFFF0A5C);
    check({resp, lpc_mode_active}, 2'b00);
    mode_set(1'b0);
    xf(1'b0, 4'h3, 28'hFFF0A5C);
    check({resp, lpc_mode_active}, 2'b11);
  endtask
  initial begin
    t_reset();
    t_read_strap();
    t_gpi();
    t_cut();
    t_protect();
    t_pins();
    give_verdict();
  end
endmodule
bind lfpc_pin_control lfpc_pin_control_properties lfpc_pin_control_properties_i (.mclk, .sys_rst,
  .parallel_program_mode, .reset_pin_n, .init_pin_n, .top_boot_lock_n, .write_protect_n, .lad_out, .lad_oe,
  .mem_req, .prog_refused, .lpc_mode_active, .dev_in_reset);
